// File: core/fsfg_fifo.sv
// Word FIFO with parity check, flush, exact count and error events
`timescale 1ns/10ps
module fsfg_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic push_valid,
   input wire logic [W-1:0] push_data,
   output logic push_ready,
   input wire logic pop,
   output logic [W-1:0] pop_data,
   output logic pop_valid_q,
   output logic [AW:0] count_q,
   output logic ovf_ev,
   output logic uvf_ev,
   output logic sed_ev
);
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [W:0] rdata;
   logic do_push;
   logic do_pop;
   logic full;
   logic empty;

   assign full = (count_q == (AW+1)'(DEPTH));
   assign empty = (count_q == '0);
   assign push_ready = !full;
   // Write at full is dropped, stored words stay intact
   assign do_push = push_valid && !full && !flush;
   assign do_pop = pop && !empty && !flush;
   assign ovf_ev = push_valid && full;
   assign uvf_ev = pop && empty;
   assign pop_data = rdata[W-1:0];
   assign sed_ev = pop_valid_q && (^rdata);

   fsfg_mem #(.W(W + 1), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .we(do_push),
      .waddr(wr_q),
      .wdata({^push_data, push_data}),
      .re(do_pop),
      .raddr(rd_q),
      .rdata_q(rdata)
   );

   always_ff @(posedge clk) begin
      if (!reset_n || flush) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pop_valid_q <= 1'b0;
      end else begin
         pop_valid_q <= do_pop;
      end
   end
endmodule

// File: core/fsfg_mem.sv
// Simple dual-port word memory with registered read data
`timescale 1ns/10ps
module fsfg_mem #(
   parameter int W = 17,
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata_q
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (re) begin
         rdata_q <= mem[raddr];
      end
   end
endmodule

// File: core/fsfg_pkg.sv
// Types shared by the FIFO status and forward gating block
package fsfg_pkg;
   typedef enum logic [1:0] {
      FSFG_ST_NORMAL = 2'h0,
      FSFG_ST_INIT = 2'h1
   } fsfg_dev_state_t;

   typedef enum logic [1:0] {
      FSFG_FW_IDLE = 2'h0,
      FSFG_FW_SEND = 2'h1,
      FSFG_FW_DROP = 2'h2
   } fsfg_fw_state_t;

   typedef struct packed {
      logic checked;
      logic discard;
      logic [9:0] len;
   } fsfg_cmd_t;

   typedef struct packed {
      logic ovf;
      logic uvf;
      logic sed;
   } fsfg_qflags_t;
endpackage

// File: core/fsfg_regs.svh
// Register offsets, field positions, reset values and sizes of the FIFO status block
`ifndef FSFG_REGS_SVH
`define FSFG_REGS_SVH
`define FSFG_ADDR_TX_LVL 8'h03
`define FSFG_ADDR_RX_LVL 8'h04
`define FSFG_ADDR_STATUS 8'h07
`define FSFG_ADDR_TX_ST 8'h09
`define FSFG_ADDR_RX_ST 8'h0A
`define FSFG_BIT_FLUSH 15
`define FSFG_BIT_CLR_ALL 15
`define FSFG_BIT_OVF 15
`define FSFG_BIT_UVF 14
`define FSFG_BIT_SED 13
`define FSFG_BIT_ST_TXFF 12
`define FSFG_BIT_ST_RXFF 11
`define FSFG_BIT_ST_DATA_READY_OUT 10
`define FSFG_BIT_ST_STATE 4
`define FSFG_BIT_ST_POR 1
`define FSFG_TX_LVL_RST 9'h1FF
`define FSFG_RX_LVL_RST 8'hFF
`define FSFG_TX_CNT_TOP 9'h1FF
`define FSFG_RX_CNT_TOP 8'hFF
`define FSFG_WORD_W 16
`define FSFG_TX_DEPTH 512
`define FSFG_TX_AW 9
`define FSFG_RX_DEPTH 256
`define FSFG_RX_AW 8
`define FSFG_CMDQ_DEPTH 4
`define FSFG_CMDQ_AW 2
`endif

// File: core/fsfg_top.sv
// FIFO status registers and downstream forward gating
//
// Summary of operation
// RULE1 - TX occupancy is 9 bits, top code 0x1FF means 511 or 512.
// RULE2 - RX occupancy is 8 bits, top code 0xFF means 255 or 256.
// RULE3 - TX overflow latches read-only flag in bit 15 of TX status.
// RULE4 - TX underflow latches read-only flag in bit 14 of TX status.
// RULE5 - TX stored word parity error latches flag in bit 13.
// RULE6 - RX overflow latches read-only flag in bit 15 of RX status.
// RULE7 - RX underflow, such as read while empty, latches bit 14.
// RULE8 - RX stored word parity error latches flag in bit 13.
// RULE9 - RX status sits at address 0xA, read-only, resets to zero.
// RULE10 - Checked forward ignores start threshold, sends only after good CRC.
// RULE11 - Forward commands queue so host may send while previous one goes out.
// RULE12 - Normal state entered only once configuration CRC is verified.
// RULE13 - No forwarding while power-on flag set; host clears it first.
// RULE14 - Host should set start threshold above largest command length.
// RULE15 - Sending starts when TX holds threshold plus one words; reset 0x1FF.
// RULE16 - Data ready goes low when RX count exceeds threshold; reset 0xFF.
// RULE17 - Writing 1 to bit 15 of a threshold register flushes that FIFO.
// RULE18 - Writing 1 to status bit 15 clears all latched flags and power-on.
// RULE19 - Error flags stay latched until cleared; full write dropped safely.
// RULE20 - Occupancy counts follow every push and pop in the same clock.
`timescale 1ns/10ps
`include "fsfg_regs.svh"
module fsfg_top
   import fsfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_q,
   input wire logic tx_push_valid,
   input wire logic [15:0] tx_push_data,
   output logic tx_push_ready,
   input wire logic cmd_done,
   input wire logic cmd_checked,
   input wire logic cmd_crc_ok,
   input wire logic [9:0] cmd_len,
   output logic cmd_ready,
   input wire logic rx_in_valid,
   input wire logic [15:0] rx_in_data,
   input wire logic rx_read,
   output logic [15:0] rx_read_data_q,
   output logic rx_read_valid_q,
   input wire logic otp_crc_ok,
   input wire logic link_clk,
   output logic [15:0] link_data_q,
   output logic link_valid_q,
   output logic data_ready_out
);
   // ****************************************************************
   // Decode and register state
   // ****************************************************************
   function automatic logic wr_bit(input logic wr, input logic [7:0] a,
                                   input logic [7:0] target, input logic b);
      return wr && (a == target) && b;
   endfunction

   logic [8:0] tx_thr_q;
   logic [7:0] rx_thr_q;
   logic tx_flush;
   logic rx_flush;
   logic clr_all;
   logic por_q;
   fsfg_dev_state_t dev_q;
   fsfg_qflags_t txf_q;
   fsfg_qflags_t rxf_q;
   fsfg_qflags_t tx_ev;
   fsfg_qflags_t rx_ev;
   logic [`FSFG_TX_AW:0] tx_count;
   logic [`FSFG_RX_AW:0] rx_count;
   logic [8:0] tx_field;
   logic [7:0] rx_field;

   assign tx_flush = wr_bit(reg_wr, reg_addr, `FSFG_ADDR_TX_LVL,
                            reg_wdata[`FSFG_BIT_FLUSH]); // [RULE17]
   assign rx_flush = wr_bit(reg_wr, reg_addr, `FSFG_ADDR_RX_LVL,
                            reg_wdata[`FSFG_BIT_FLUSH]); // [RULE17]
   assign clr_all = wr_bit(reg_wr, reg_addr, `FSFG_ADDR_STATUS,
                           reg_wdata[`FSFG_BIT_CLR_ALL]);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_thr_q <= `FSFG_TX_LVL_RST; // [RULE15]
         rx_thr_q <= `FSFG_RX_LVL_RST; // [RULE16]
      end else if (reg_wr) begin
         if (reg_addr == `FSFG_ADDR_TX_LVL) begin
            tx_thr_q <= reg_wdata[8:0];
         end
         if (reg_addr == `FSFG_ADDR_RX_LVL) begin
            rx_thr_q <= reg_wdata[7:0];
         end
      end
   end

   // Flags latch until clear; a new event in the clear cycle wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         txf_q <= '0;
         rxf_q <= '0;
         por_q <= 1'b1;
      end else begin
         txf_q <= (clr_all ? '0 : txf_q) | tx_ev; // [RULE3] [RULE4] [RULE5] [RULE19]
         rxf_q <= (clr_all ? '0 : rxf_q) | rx_ev; // [RULE6] [RULE7] [RULE8] [RULE19]
         if (clr_all) begin
            por_q <= 1'b0; // [RULE18]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dev_q <= FSFG_ST_INIT;
      end else begin
         case (dev_q)
            FSFG_ST_INIT: begin
               if (otp_crc_ok) begin
                  dev_q <= FSFG_ST_NORMAL; // [RULE12]
               end
            end
            default: begin
               dev_q <= FSFG_ST_NORMAL;
            end
         endcase
      end
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   assign tx_field = (tx_count[`FSFG_TX_AW]) ? `FSFG_TX_CNT_TOP
                     : tx_count[8:0]; // [RULE1] [RULE20]
   assign rx_field = (rx_count[`FSFG_RX_AW]) ? `FSFG_RX_CNT_TOP
                     : rx_count[7:0]; // [RULE2] [RULE20]

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `FSFG_ADDR_TX_LVL: reg_rdata_q <= {7'h00, tx_thr_q};
            `FSFG_ADDR_RX_LVL: reg_rdata_q <= {8'h00, rx_thr_q};
            `FSFG_ADDR_STATUS: reg_rdata_q <= {3'h0, |txf_q, |rxf_q, data_ready_out,
                                               4'h0, 2'(dev_q), 2'h0, por_q, 1'b0};
            `FSFG_ADDR_TX_ST: reg_rdata_q <= {txf_q, 4'h0, tx_field};
            `FSFG_ADDR_RX_ST: reg_rdata_q <= {rxf_q, 5'h00, rx_field}; // [RULE9]
            default: reg_rdata_q <= 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // Link clock edge detection
   // ****************************************************************
   logic [2:0] lclk_q;
   logic link_edge;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lclk_q <= 3'h0;
      end else begin
         lclk_q <= {lclk_q[1:0], link_clk};
      end
   end
   assign link_edge = lclk_q[1] && !lclk_q[2];

   // ****************************************************************
   // Forward command queue
   // ****************************************************************
   fsfg_cmd_t cmdq_q [`FSFG_CMDQ_DEPTH];
   logic [`FSFG_CMDQ_AW-1:0] cq_wr_q;
   logic [`FSFG_CMDQ_AW-1:0] cq_rd_q;
   logic [`FSFG_CMDQ_AW:0] cq_cnt_q;
   logic cq_push;
   logic cq_pop;
   fsfg_cmd_t head;

   assign cmd_ready = (cq_cnt_q != (`FSFG_CMDQ_AW+1)'(`FSFG_CMDQ_DEPTH));
   assign cq_push = cmd_done && cmd_ready && !tx_flush;
   assign head = cmdq_q[cq_rd_q];

   always_ff @(posedge clk) begin
      if (cq_push) begin
         cmdq_q[cq_wr_q] <= '{checked: cmd_checked, discard: cmd_checked && !cmd_crc_ok,
                              len: cmd_len}; // [RULE10]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || tx_flush) begin
         cq_wr_q <= '0;
         cq_rd_q <= '0;
         cq_cnt_q <= '0;
      end else begin
         if (cq_push) begin
            cq_wr_q <= cq_wr_q + 1'b1; // [RULE11]
         end
         if (cq_pop) begin
            cq_rd_q <= cq_rd_q + 1'b1;
         end
         cq_cnt_q <= cq_cnt_q + (`FSFG_CMDQ_AW+1)'(cq_push) - (`FSFG_CMDQ_AW+1)'(cq_pop);
      end
   end

   // ****************************************************************
   // Forward engine
   // ****************************************************************
   fsfg_fw_state_t fw_q;
   logic [9:0] remain_q;
   logic fwd_allowed;
   logic thr_met;
   logic tx_pop;
   logic tx_pop_valid;
   logic drop_d_q;
   logic [15:0] tx_pop_data;

   assign fwd_allowed = (dev_q == FSFG_ST_NORMAL) && !por_q; // [RULE12] [RULE13]
   assign thr_met = (tx_count >= ({1'b0, tx_thr_q} + 10'h001)); // [RULE15]
   assign tx_pop = ((fw_q == FSFG_FW_SEND && link_edge) || fw_q == FSFG_FW_DROP)
                   && (remain_q != 10'h000);
   assign cq_pop = (fw_q != FSFG_FW_IDLE) && !tx_flush
                   && ((remain_q == 10'h000) || (tx_pop && tx_ev.uvf));

   always_ff @(posedge clk) begin
      if (!reset_n || tx_flush) begin
         fw_q <= FSFG_FW_IDLE;
         remain_q <= 10'h000;
      end else begin
         case (fw_q)
            FSFG_FW_IDLE: begin
               if (cq_cnt_q != '0) begin
                  remain_q <= head.len;
                  if (head.discard) begin
                     fw_q <= FSFG_FW_DROP; // [RULE10]
                  end else if (fwd_allowed && (head.checked || thr_met)) begin
                     fw_q <= FSFG_FW_SEND; // [RULE10] [RULE13] [RULE15]
                  end
               end
            end
            FSFG_FW_SEND, FSFG_FW_DROP: begin
               if (cq_pop) begin
                  fw_q <= FSFG_FW_IDLE;
               end else if (tx_pop) begin
                  remain_q <= remain_q - 10'h001;
               end
            end
            default: begin
               fw_q <= FSFG_FW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drop_d_q <= 1'b0;
         link_valid_q <= 1'b0;
         link_data_q <= 16'h0000;
      end else begin
         drop_d_q <= (fw_q == FSFG_FW_DROP);
         link_valid_q <= tx_pop_valid && !drop_d_q;
         if (tx_pop_valid && !drop_d_q) begin
            link_data_q <= tx_pop_data;
         end
      end
   end

   // ****************************************************************
   // FIFOs
   // ****************************************************************
   fsfg_fifo #(.W(`FSFG_WORD_W), .DEPTH(`FSFG_TX_DEPTH), .AW(`FSFG_TX_AW)) u_tx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(tx_flush),
      .push_valid(tx_push_valid),
      .push_data(tx_push_data),
      .push_ready(tx_push_ready),
      .pop(tx_pop),
      .pop_data(tx_pop_data),
      .pop_valid_q(tx_pop_valid),
      .count_q(tx_count),
      .ovf_ev(tx_ev.ovf),
      .uvf_ev(tx_ev.uvf),
      .sed_ev(tx_ev.sed)
   );

   logic [15:0] rx_pop_data;
   logic rx_pop_valid;

   fsfg_fifo #(.W(`FSFG_WORD_W), .DEPTH(`FSFG_RX_DEPTH), .AW(`FSFG_RX_AW)) u_rx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(rx_flush),
      .push_valid(rx_in_valid),
      .push_data(rx_in_data),
      .push_ready(),
      .pop(rx_read),
      .pop_data(rx_pop_data),
      .pop_valid_q(rx_pop_valid),
      .count_q(rx_count),
      .ovf_ev(rx_ev.ovf),
      .uvf_ev(rx_ev.uvf),
      .sed_ev(rx_ev.sed)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_read_valid_q <= 1'b0;
         rx_read_data_q <= 16'h0000;
      end else begin
         rx_read_valid_q <= rx_pop_valid;
         if (rx_pop_valid) begin
            rx_read_data_q <= rx_pop_data;
         end
      end
   end

   assign data_ready_out = !(rx_count > {1'b0, rx_thr_q}); // [RULE16]

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_TX_TOP_CODE: assert property (tx_count >= 10'h1FF |-> tx_field == 9'h1FF) // [RULE1]
      else $error("tx count field not saturated");
   AST_RX_TOP_CODE: assert property (rx_count >= 9'h0FF |-> rx_field == 8'hFF) // [RULE2]
      else $error("rx count field not saturated");
   AST_TX_OVF: assert property (tx_push_valid && !tx_push_ready |=> txf_q.ovf) // [RULE3]
      else $error("tx overflow not flagged");
   AST_TX_UVF: assert property (tx_pop && tx_count == '0 |=> txf_q.uvf) // [RULE4]
      else $error("tx underflow not flagged");
   AST_RX_OVF: assert property (rx_in_valid && rx_count == 9'h100 |=> rxf_q.ovf) // [RULE6]
      else $error("rx overflow not flagged");
   AST_RX_UVF: assert property (rx_read && rx_count == '0 |=> rxf_q.uvf) // [RULE7]
      else $error("rx underflow not flagged");
   AST_RX_READ: assert property (rx_read && rx_count != '0 && !rx_flush |-> ##2 rx_read_valid_q)
      else $error("rx read data not delivered in two cycles");
   AST_POR_GATE: assert property (por_q |-> fw_q != FSFG_FW_SEND) // [RULE13]
      else $error("forwarding while power-on flag set");
   AST_INIT_GATE: assert property (dev_q == FSFG_ST_INIT |=> fw_q != FSFG_FW_SEND) // [RULE12]
      else $error("forwarding before configuration check");
   AST_CLR_ALL: assert property (clr_all && tx_ev == '0 && rx_ev == '0
                                 |=> txf_q == '0 && rxf_q == '0 && !por_q) // [RULE18]
      else $error("clear all did not clear flags");
   AST_FLUSH: assert property (tx_flush |=> tx_count == '0 && fw_q == FSFG_FW_IDLE) // [RULE17]
      else $error("tx flush did not empty fifo");
   AST_COUNT: assert property (tx_push_valid && tx_push_ready && !tx_pop && !tx_flush
                               |=> tx_count == $past(tx_count) + 10'h001) // [RULE20]
      else $error("tx count did not follow push");

   COV_CHECKED_SEND: cover property (fw_q == FSFG_FW_IDLE ##1 fw_q == FSFG_FW_SEND
                                     && $past(head.checked));
   COV_BAD_CRC_DROP: cover property (fw_q == FSFG_FW_DROP);
   COV_DATA_READY_OUT_LOW: cover property ($fell(data_ready_out));
endmodule

// File: dv/fsfg_link_model.sv
// Downstream link clock source standing in for the LED driver chain
`timescale 1ns/10ps
module fsfg_link_model (
   input wire logic run,
   output logic link_clk
);
   // Free phase against clk; stands still low while run is low
   initial begin
      link_clk = 1'b0;
      #37;
      forever begin
         #400;
         if (run || link_clk) begin
            link_clk = ~link_clk;
         end
      end
   end
endmodule

// File: dv/tb.sv
// Self-checking testbench of the FIFO status and forward gating block
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   import fsfg_pkg::*;
   logic clk, reset_n, reg_wr, reg_rd, tx_push_valid, cmd_done, cmd_checked, cmd_crc_ok;
   logic rx_in_valid, rx_read, otp_crc_ok, link_clk, run, rd_seen;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, tx_push_data, rx_in_data, e_v;
   logic [9:0] cmd_len;
   logic [15:0] reg_rdata_q, rx_read_data_q, link_data_q;
   logic tx_push_ready, cmd_ready, rx_read_valid_q, link_valid_q, data_ready_out;
   logic [15:0] rq[$], lq[$], xq[$];
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   // ********************
   // Design and partner
   // ********************
   fsfg_top uut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .tx_push_valid(tx_push_valid), .tx_push_data(tx_push_data),
      .tx_push_ready(tx_push_ready), .cmd_done(cmd_done), .cmd_checked(cmd_checked),
      .cmd_crc_ok(cmd_crc_ok), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
      .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_read(rx_read),
      .rx_read_data_q(rx_read_data_q), .rx_read_valid_q(rx_read_valid_q),
      .otp_crc_ok(otp_crc_ok), .link_clk(link_clk), .link_data_q(link_data_q),
      .link_valid_q(link_valid_q), .data_ready_out(data_ready_out));
   fsfg_link_model link (.run(run), .link_clk(link_clk));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ********************
   // Result watcher
   // ********************
   always @(posedge clk) rd_seen <= reg_rd && reset_n;
   always @(negedge clk) begin
      if (rd_seen) begin
         e_v = rq.pop_front();
         `CHK(reg_rdata_q, e_v)
      end
      if (link_valid_q === 1'b1) begin
         if (lq.size() == 0) `CHK(1'b1, 1'b0) else begin
            e_v = lq.pop_front();
            `CHK(link_data_q, e_v)
         end
      end
      if (rx_read_valid_q === 1'b1) begin
         if (xq.size() == 0) `CHK(1'b1, 1'b0) else begin
            e_v = xq.pop_front();
            `CHK(rx_read_data_q, e_v)
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   // ********************
   // Driver tasks
   // ********************
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk) reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk) reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      rq.push_back(e);
      @(negedge clk) reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk) reg_rd = 1'b0;
   endtask
   task automatic pushn(input int n, input bit note);
      for (int i = 0; i < n; i++) begin
         @(negedge clk) tx_push_valid = 1'b1;
         tx_push_data = 16'($urandom);
         if (note) lq.push_back(tx_push_data);
      end
      @(negedge clk) tx_push_valid = 1'b0;
   endtask
   task automatic cmd(input logic [9:0] n, input logic chk, input logic ok);
      @(negedge clk) cmd_done = 1'b1;
      cmd_len = n;
      cmd_checked = chk;
      cmd_crc_ok = ok;
      @(negedge clk) cmd_done = 1'b0;
   endtask
   task automatic rxin(input int n, input bit note);
      for (int i = 0; i < n; i++) begin
         @(negedge clk) rx_in_valid = 1'b1;
         rx_in_data = 16'($urandom);
         if (note) xq.push_back(rx_in_data);
      end
      @(negedge clk) rx_in_valid = 1'b0;
   endtask
   task automatic rxrd();
      @(negedge clk) rx_read = 1'b1;
      @(negedge clk) rx_read = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && lq.size() != 0; i++) @(negedge clk);
      idle(20);
   endtask
   task automatic summarize();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ********************
   // Main sequence
   // ********************
   initial begin
      {reset_n, reg_wr, reg_rd, tx_push_valid, cmd_done, cmd_checked, cmd_crc_ok} = '0;
      {rx_in_valid, rx_read, otp_crc_ok, run} = '0;
      {reg_addr, reg_wdata, tx_push_data, rx_in_data, cmd_len} = '0;
      void'($urandom(89306));
      idle(5);
      reset_n = 1'b1;
      wr(8'h0A, 16'hFFFF);
      rd(8'h0A, 16'h0000);
      rd(8'h09, 16'h0000);
      rd(8'h03, 16'h01FF);
      rd(8'h04, 16'h00FF);
      rd(8'h07, 16'h0412);
      rd(8'h55, 16'h0000);
      otp_crc_ok = 1'b1;
      idle(2);
      rd(8'h07, 16'h0402);
      // Unchecked forward held back by power-on flag
      wr(8'h03, 16'h0001);
      pushn(2, 1);
      cmd(2, 1'b0, 1'b0);
      run = 1'b1;
      idle(40);
      rd(8'h09, 16'h0002);
      wr(8'h07, 16'h8000);
      drain();
      rd(8'h07, 16'h0400);
      rd(8'h09, 16'h0000);
      // Start threshold of three, so sending waits for four words
      wr(8'h03, 16'h0003);
      pushn(3, 1);
      cmd(3, 1'b0, 1'b0);
      idle(40);
      rd(8'h09, 16'h0003);
      pushn(1, 0);
      drain();
      rd(8'h09, 16'h0001);
      wr(8'h03, 16'h8003);
      rd(8'h09, 16'h0000);
      rd(8'h03, 16'h0003);
      // Checked forwards queued back to back, then a bad trailing check word
      pushn(3, 1);
      cmd(3, 1'b1, 1'b1);
      pushn(2, 1);
      cmd(2, 1'b1, 1'b1);
      drain();
      pushn(2, 0);
      cmd(2, 1'b1, 1'b0);
      idle(60);
      rd(8'h09, 16'h0000);
      // Command longer than the stored words
      pushn(1, 1);
      cmd(2, 1'b1, 1'b1);
      drain();
      rd(8'h09, 16'h4000);
      rd(8'h07, 16'h1400);
      wr(8'h07, 16'h8000);
      rd(8'h09, 16'h0000);
      run = 1'b0;
      // Transmit side filled to full
      wr(8'h03, 16'h01FF);
      pushn(510, 0);
      rd(8'h09, 16'h01FE);
      pushn(1, 0);
      rd(8'h09, 16'h01FF);
      pushn(1, 0);
      rd(8'h09, 16'h01FF);
      `CHK(tx_push_ready, 1'b0)
      // Link clock stopped, so queued commands pile up until the queue is full
      repeat (4) cmd(10'h001, 1'b0, 1'b0);
      `CHK(cmd_ready, 1'b0)
      pushn(1, 0);
      rd(8'h09, 16'h81FF);
      wr(8'h03, 16'h81FF);
      wr(8'h07, 16'h8000);
      rd(8'h09, 16'h0000);
      // Stored word corrupted in place, then discarded by a bad check word
      pushn(1, 0);
      uut.u_tx_fifo.u_mem.mem[0] = uut.u_tx_fifo.u_mem.mem[0] ^ 17'h00001;
      cmd(1, 1'b1, 1'b0);
      idle(6);
      rd(8'h09, 16'h2000);
      // Receive side
      rxrd();
      idle(2);
      rd(8'h0A, 16'h4000);
      wr(8'h07, 16'h8000);
      wr(8'h04, 16'h0001);
      rxin(1, 1);
      `CHK(data_ready_out, 1'b1)
      rxin(1, 1);
      `CHK(data_ready_out, 1'b0)
      rd(8'h07, 16'h0000);
      rxrd();
      rxrd();
      idle(3);
      rd(8'h0A, 16'h0000);
      wr(8'h04, 16'h00FF);
      rxin(254, 1);
      rd(8'h0A, 16'h00FE);
      rxin(2, 1);
      rd(8'h0A, 16'h00FF);
      rxin(1, 0);
      rd(8'h0A, 16'h80FF);
      rd(8'h07, 16'h0800);
      rxrd();
      idle(3);
      wr(8'h04, 16'h80FF);
      xq.delete();
      rd(8'h0A, 16'h8000);
      // Stored receive word corrupted in place before it is read
      rxin(1, 1);
      uut.u_rx_fifo.u_mem.mem[0] = uut.u_rx_fifo.u_mem.mem[0] ^ 17'h00001;
      xq[0] = xq[0] ^ 16'h0001;
      rxrd();
      idle(3);
      rd(8'h0A, 16'hA000);
      idle(4);
      `CHK(rq.size(), 0)
      summarize();
   end
endmodule
